// ---- rtl/fieldbus_ctrl_status_word.sv ----
// Command word gating and state report word assembly for the fieldbus slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: Data-valid low: ignore new command word, keep last accepted value.
// R02: Data-valid high: use the command word received in this transfer.
// R03: Gating covers only the command word, not other process data.
// R04: Watchdog bit always taken from newest received command word.
// R05: Held command word starts at default 0x5 until valid word accepted.
// R06: Default command word substituted while watchdog fault is active.
// R07: Master toggles bit 11; device feeds it to watchdog supervision.
// R08: Bits 12 to 15 switch four vendor functions on or off.
// R09: Status bit 0: switch-on, breaker enable, no quick stop, no fault.
// R10: Status bit 0 matches the dedicated ready input when present.
// R11: Status bit 1 set when power unit can start.
// R12: Status bit 2 set while modulating, clear when stopped.
// R13: Status bit 3 set while any fault event is active.
// R14: Command bit 2 low requests quick stop.
// R15: Status bit 15 returns the received watchdog bit.
// R16: Command bits 8 and 9 reserved and ignored.
module fieldbus_ctrl_status_word
    import cw_pkg::*;
#(
    parameter int VEND_W = cw_pkg::VEND_N
) (
    // Clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    // Command word from the fieldbus slave, one-cycle strobe
    input  wire logic [cw_pkg::WORD_W-1:0] cmd_word_i,
    input  wire logic                      cmd_stb_i,
    // Other process data word, passed ungated
    input  wire logic [cw_pkg::WORD_W-1:0] pd_word_i,
    input  wire logic                      pd_stb_i,
    // Unit state inputs, asynchronous levels
    input  wire logic                      wdog_fault_i,
    input  wire logic                      fault_any_i,
    input  wire logic                      pu_ready_i,
    input  wire logic                      modulating_i,
    input  wire logic                      ready_din_present_i,
    input  wire logic                      ready_din_i,
    // Outputs to the unit
    output logic [cw_pkg::WORD_W-1:0]      cmd_held_o,
    output logic [cw_pkg::WORD_W-1:0]      pd_word_o,
    output logic                           wdog_bit_o,
    output logic                           quick_stop_o,
    output logic [VEND_W-1:0]              vendor_on_o,
    // State report word to the master
    output logic [cw_pkg::WORD_W-1:0]      state_report_word_o
);
    import cw_pkg::*;

    // ************************************
    // Input synchronisation
    // ************************************
    logic [5:0] st_s;

    cw_sync2 #(
        .W (6)
    ) u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({wdog_fault_i, fault_any_i, pu_ready_i, modulating_i, ready_din_present_i, ready_din_i}),
        .q_o    (st_s)
    );

    logic wdog_fault_s;
    logic fault_s;
    logic pu_ready_s;
    logic mod_s;
    logic din_pres_s;
    logic din_s;
    assign {wdog_fault_s, fault_s, pu_ready_s, mod_s, din_pres_s, din_s} = st_s;

    // ************************************
    // Command word hold
    // ************************************
    logic [WORD_W-1:0] accepted_q;
    logic [WORD_W-1:0] accepted_d;
    logic [WORD_W-1:0] held_d;
    logic              wdog_q;
    logic              wdog_d;
    logic [WORD_W-1:0] pd_q;
    logic [WORD_W-1:0] pd_d;

    always_comb begin
        accepted_d = accepted_q;
        wdog_d     = wdog_q;
        pd_d       = pd_q;
        // R01 R02 accept when valid
        if (cmd_stb_i && cmd_word_i[CMD_VALID]) begin
            accepted_d = cmd_word_i;
        end
        // R04 R07 watchdog always newest
        if (cmd_stb_i) begin
            wdog_d = cmd_word_i[CMD_WDOG];
        end
        // R03 other words not gated
        if (pd_stb_i) begin
            pd_d = pd_word_i;
        end
        // R06 default under watchdog fault
        held_d = wdog_fault_s ? CMD_DEFAULT : accepted_d;
        // R16 reserved bits dropped
        held_d[CMD_RSVD_LO] = 1'b0;
        held_d[CMD_RSVD_HI] = 1'b0;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            // R05 default start value
            accepted_q <= CMD_DEFAULT;
            cmd_held_o <= CMD_DEFAULT;
            wdog_q     <= 1'b0;
            pd_q       <= '0;
        end else begin
            accepted_q <= accepted_d;
            cmd_held_o <= held_d;
            wdog_q     <= wdog_d;
            pd_q       <= pd_d;
        end
    end

    assign pd_word_o  = pd_q;
    assign wdog_bit_o = wdog_q;

    // ************************************
    // Decoded controls
    // ************************************
    logic               qstop_q;
    logic               qstop_d;
    logic [VEND_W-1:0]  vend_q;
    logic [VEND_W-1:0]  vend_d;

    always_comb begin
        // R14 quick stop active low
        qstop_d = ~held_d[CMD_QSTOP_N];
        // R08 vendor function enables
        vend_d  = held_d[CMD_VEND_LO +: VEND_W];
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            qstop_q <= ~CMD_DEFAULT[CMD_QSTOP_N];
            vend_q  <= CMD_DEFAULT[CMD_VEND_LO +: VEND_W];
        end else begin
            qstop_q <= qstop_d;
            vend_q  <= vend_d;
        end
    end

    assign quick_stop_o = qstop_q;
    assign vendor_on_o  = vend_q;

    // ************************************
    // State report word
    // ************************************
    logic [WORD_W-1:0] rep_q;
    logic [WORD_W-1:0] rep_d;
    logic              permit;

    always_comb begin
        // R09 startup permitted
        permit = cmd_held_o[CMD_SW_ON] && cmd_held_o[CMD_BRK_EN] && !qstop_q && !fault_s;
        rep_d  = '0;
        // R10 follow dedicated input
        rep_d[ST_PERMIT]   = din_pres_s ? din_s : permit;
        // R11 power unit ready
        rep_d[ST_PU_READY] = pu_ready_s;
        // R12 running
        rep_d[ST_RUNNING]  = mod_s;
        // R13 fault
        rep_d[ST_FAULT]    = fault_s;
        // R15 watchdog echo
        rep_d[ST_WDOG]     = wdog_q;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rep_q <= '0;
        end else begin
            rep_q <= rep_d;
        end
    end

    assign state_report_word_o = rep_q;

    // ************************************
    // Checks
    // ************************************
    property p_hold_invalid;
        @(posedge mclk_i) disable iff (rst_i)
        (cmd_stb_i && !cmd_word_i[CMD_VALID] && !pd_stb_i) |=> (accepted_q == $past(accepted_q));
    endproperty
    a_hold_invalid: assert property (p_hold_invalid) else $error("invalid word changed hold"); // R01

    property p_take_valid;
        @(posedge mclk_i) disable iff (rst_i)
        (cmd_stb_i && cmd_word_i[CMD_VALID]) |=> (accepted_q == $past(cmd_word_i));
    endproperty
    a_take_valid: assert property (p_take_valid) else $error("valid word not taken"); // R02

    property p_pd_free;
        @(posedge mclk_i) disable iff (rst_i)
        pd_stb_i |=> (pd_word_o == $past(pd_word_i));
    endproperty
    a_pd_free: assert property (p_pd_free) else $error("process data gated"); // R03

    property p_wdog_new;
        @(posedge mclk_i) disable iff (rst_i)
        cmd_stb_i |=> (wdog_bit_o == $past(cmd_word_i[CMD_WDOG]));
    endproperty
    a_wdog_new: assert property (p_wdog_new) else $error("watchdog bit not newest"); // R04

    property p_wdog_default;
        @(posedge mclk_i) disable iff (rst_i)
        wdog_fault_s |=> (cmd_held_o == CMD_DEFAULT);
    endproperty
    a_wdog_default: assert property (p_wdog_default) else $error("default not applied"); // R06

    property p_vendor;
        @(posedge mclk_i) disable iff (rst_i)
        ##1 (vendor_on_o == $past(held_d[CMD_VEND_LO +: VEND_W]));
    endproperty
    a_vendor: assert property (p_vendor) else $error("vendor outputs wrong"); // R08

    property p_permit;
        @(posedge mclk_i) disable iff (rst_i)
        !din_pres_s |=> (state_report_word_o[ST_PERMIT] == $past(permit));
    endproperty
    a_permit: assert property (p_permit) else $error("startup permitted wrong"); // R09

    property p_echo;
        @(posedge mclk_i) disable iff (rst_i)
        cmd_stb_i |-> ##2 (state_report_word_o[ST_WDOG] == $past(cmd_word_i[CMD_WDOG], 2));
    endproperty
    a_echo: assert property (p_echo) else $error("watchdog echo wrong"); // R15

    property p_fault;
        @(posedge mclk_i) disable iff (rst_i)
        ##1 (state_report_word_o[ST_FAULT] == $past(fault_s));
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit wrong"); // R13
endmodule
`default_nettype wire

// ---- rtl/cw_pkg.sv ----
// Package: field positions, defaults and widths of the command and state report words
`default_nettype none
package cw_pkg;
    localparam int          WORD_W       = 16;
    localparam logic [15:0] CMD_DEFAULT  = 16'h0005;
    localparam int          CMD_SW_ON    = 0;
    localparam int          CMD_BRK_EN   = 1;
    localparam int          CMD_QSTOP_N  = 2;
    localparam int          CMD_RSVD_LO  = 8;
    localparam int          CMD_RSVD_HI  = 9;
    localparam int          CMD_VALID    = 10;
    localparam int          CMD_WDOG     = 11;
    localparam int          CMD_VEND_LO  = 12;
    localparam int          VEND_N       = 4;
    localparam int          ST_PERMIT    = 0;
    localparam int          ST_PU_READY  = 1;
    localparam int          ST_RUNNING   = 2;
    localparam int          ST_FAULT     = 3;
    localparam int          ST_WDOG      = 15;
endpackage
`default_nettype wire

// ---- rtl/cw_sync2.sv ----
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module cw_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;

    always_comb begin
        s1_d = d_i;
        s2_d = s1_q;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            q_o  <= '0;
        end else begin
            s1_q <= s1_d;
            q_o  <= s2_d;
        end
    end
endmodule
`default_nettype wire

// ---- bench/modbus_master_model.sv ----
// Fieldbus master model: delivers command and process data words
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
    // Clock
    input  wire logic        mclk_i,
    // Words towards the block
    output logic      [15:0] cmd_word_o,
    output logic             cmd_stb_o,
    output logic      [15:0] pd_word_o,
    output logic             pd_stb_o
);
    initial begin
        cmd_word_o = 16'h0000;
        cmd_stb_o  = 1'b0;
        pd_word_o  = 16'h0000;
        pd_stb_o   = 1'b0;
    end

    task automatic send(input logic pd, input logic [15:0] w);
        @(negedge mclk_i);
        if (pd) begin
            pd_word_o = w;
            pd_stb_o  = 1'b1;
        end else begin
            cmd_word_o = w;
            cmd_stb_o  = 1'b1;
        end
        @(negedge mclk_i);
        // Stale data is inverted so a late sample is caught
        cmd_stb_o  = 1'b0;
        pd_stb_o   = 1'b0;
        cmd_word_o = ~cmd_word_o;
        pd_word_o  = ~pd_word_o;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_fieldbus_ctrl_status_word.sv ----
// Testbench: command word gating and state report word
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_ctrl_status_word;
    import cw_pkg::*;
    logic        mclk_i, rst_i, cmd_stb_i, pd_stb_i, wdog_bit_o, quick_stop_o;
    logic        wdog_fault_i, fault_any_i, pu_ready_i, modulating_i;
    logic        ready_din_present_i, ready_din_i;
    logic [15:0] cmd_word_i, pd_word_i, cmd_held_o, pd_word_o, state_report_word_o;
    logic [3:0]  vendor_on_o;
    int          fails, checks_done, cycles;

    fieldbus_ctrl_status_word DUT (.mclk_i, .rst_i, .cmd_word_i, .cmd_stb_i, .pd_word_i,
        .pd_stb_i, .wdog_fault_i, .fault_any_i, .pu_ready_i, .modulating_i, .ready_din_present_i,
        .ready_din_i, .cmd_held_o, .pd_word_o, .wdog_bit_o, .quick_stop_o, .vendor_on_o,
        .state_report_word_o);
    modbus_master_model master (.mclk_i, .cmd_word_o(cmd_word_i), .cmd_stb_o(cmd_stb_i),
        .pd_word_o(pd_word_i), .pd_stb_o(pd_stb_i));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wt();
        repeat (6) @(negedge mclk_i);
    endtask

    task automatic test_done();
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard, far above the roughly 60 cycles needed
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            test_done();
        end
    end

    task automatic t_invalid_word();
        master.send(1'b0, 16'h0800);
        chk(cmd_held_o, CMD_DEFAULT);
        chk(16'(wdog_bit_o), 16'h0001);
        wt();
        chk(state_report_word_o, 16'h8000);
    endtask

    task automatic t_valid_word();
        master.send(1'b0, 16'h5707);
        chk(cmd_held_o, 16'h5407);
        chk(16'(vendor_on_o), 16'h0005);
        chk(16'(quick_stop_o), 16'h0000);
        master.send(1'b0, 16'h0000);
        chk(cmd_held_o, 16'h5407);
        master.send(1'b1, 16'habcd);
        chk(pd_word_o, 16'habcd);
        wt();
        chk(state_report_word_o, 16'h0001);
    endtask

    task automatic t_wdog_fault();
        wdog_fault_i = 1'b1;
        wt();
        chk(cmd_held_o, CMD_DEFAULT);
        wdog_fault_i = 1'b0;
        wt();
        chk(cmd_held_o, 16'h5407);
    endtask

    task automatic t_status();
        fault_any_i  = 1'b1;
        pu_ready_i   = 1'b1;
        modulating_i = 1'b1;
        wt();
        chk(state_report_word_o, 16'h000e);
        fault_any_i = 1'b0;
        ready_din_present_i = 1'b1;
        wt();
        chk(state_report_word_o, 16'h0006);
        ready_din_i = 1'b1;
        wt();
        chk(state_report_word_o, 16'h0007);
        ready_din_present_i = 1'b0;
        master.send(1'b0, 16'ha400);
        chk(16'(quick_stop_o), 16'h0001);
        chk(16'(vendor_on_o), 16'h000a);
        wt();
        chk(state_report_word_o, 16'h0006);
    endtask

    initial begin
        {fails, checks_done, cycles} = '0;
        rst_i = 1'b1;
        {wdog_fault_i, fault_any_i, pu_ready_i, modulating_i} = 4'h0;
        {ready_din_present_i, ready_din_i} = 2'h0;
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        chk(cmd_held_o, CMD_DEFAULT);
        chk(state_report_word_o, 16'h0000);
        t_invalid_word();
        t_valid_word();
        t_wdog_fault();
        t_status();
        test_done();
    end
endmodule
`default_nettype wire
